// File: rtl/swrhs_top.sv
// Sleep/wake rail hand-over and standby regulator undervoltage sequencer.
// Assumes sleep pins are asynchronous, UV and 12V comparators asynchronous.
// Functional notes
// - Direct move from S4/S5 into S3 is refused; previous state kept.
// - In S0, watch the 12V rail and note its first power-on crossing.
// - Wait three soft-start periods after 12V good, then hand over at once.
// - At hand-over release the open-drain main-switch gate to high-Z.
// - At hand-over drive the standby-switch gate high.
// - At hand-over place the standby linear regulator in standby.
// - UV detection only in sleep and after initial soft-start completed.
// - UV trip is 25 percent below nominal, 2.475 V, from comparator.
// - On UV disable the standby linear regulator at once.
// - One soft-start interval later re-enable it, with soft-start already marked done.
// - After three retries a fourth UV latches the regulator off.
// - Overcurrent droop reaching the UV trip starts the same handling.
module swrhs_top
   import swrhs_pkg::*;
#(
   parameter int SS_CYC = SS_CYCLES
)(
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic sleep_s3_n_in,
   input  wire logic sleep_s5_n_in,
   input  wire logic rail_12v_good_in,
   input  wire logic aux_3v3_uv_in,
   output logic      main_switch_gate_release_o_out,
   output logic      main_switch_gate_release_oe_out,
   output logic      standby_switch_gate_drive_out,
   output logic      standby_linear_regulator_en_out,
   output logic      standby_linear_regulator_stby_out,
   output logic      standby_latched_off_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic s3_n;
   logic s5_n;
   logic good12;
   logic uv;

   swrhs_sync u_s3 (.clk_in(clk_in), .resetn_in(resetn_in),
                    .pin_in(sleep_s3_n_in), .level_out(s3_n));
   swrhs_sync u_s5 (.clk_in(clk_in), .resetn_in(resetn_in),
                    .pin_in(sleep_s5_n_in), .level_out(s5_n));
   swrhs_sync u_12 (.clk_in(clk_in), .resetn_in(resetn_in),
                    .pin_in(rail_12v_good_in), .level_out(good12));
   swrhs_sync u_uv (.clk_in(clk_in), .resetn_in(resetn_in),
                    .pin_in(aux_3v3_uv_in), .level_out(uv));

   ////////////////////////////////////////////////////////////////////////////
   // Sleep state decode
   swrhs_sleep_t state;
   swrhs_sleep_t next_state;
   logic [CNT_W-1:0] dly;
   logic [CNT_W-1:0] next_dly;

   always_comb begin
      next_state = state;
      next_dly   = '0;
      unique case ({s5_n, s3_n})
         2'b11: next_state = SWRHS_ACTIVE;
         2'b00: next_state = SWRHS_S45;
         2'b10: begin
            if (state == SWRHS_ACTIVE) begin
               next_dly = dly + 1'b1;
               if (dly >= CNT_W'(S3_DELAY_CYCLES - 1)) begin
                  next_state = SWRHS_S3;
               end
            end else if (state == SWRHS_S45) begin
               next_state = SWRHS_S45;
            end else begin
               next_state = SWRHS_S3;
            end
         end
         2'b01: next_state = state;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= SWRHS_S45;
         dly   <= '0;
      end else begin
         state <= next_state;
         dly   <= next_dly;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake hand-over
   logic             good_seen;
   logic             handed;
   logic [CNT_W+1:0] hcnt;
   logic             next_good_seen;
   logic             next_handed;
   logic [CNT_W+1:0] next_hcnt;
   localparam int    HO_CYC = HANDOVER_PERIODS * SS_CYC;

   always_comb begin
      next_good_seen = good_seen;
      next_handed    = handed;
      next_hcnt      = hcnt;
      if (state != SWRHS_ACTIVE) begin
         next_good_seen = 1'b0;
         next_handed    = 1'b0;
         next_hcnt      = '0;
      end else if (!good_seen) begin
         next_good_seen = good12;
      end else if (!handed) begin
         next_hcnt = hcnt + 1'b1;
         if (hcnt == (CNT_W+2)'(HO_CYC - 1)) begin
            next_handed = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         good_seen <= 1'b0;
         handed    <= 1'b0;
         hcnt      <= '0;
      end else begin
         good_seen <= next_good_seen;
         handed    <= next_handed;
         hcnt      <= next_hcnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standby regulator soft-start, UV retry and latch-off
   logic             ss_done;
   logic             ldo_off;
   logic             latched;
   logic [1:0]       retries;
   logic [CNT_W-1:0] scnt;
   logic             next_ss_done;
   logic             next_ldo_off;
   logic             next_latched;
   logic [1:0]       next_retries;
   logic [CNT_W-1:0] next_scnt;
   logic             uv_armed;

   assign uv_armed = (state != SWRHS_ACTIVE) && ss_done && !ldo_off
                     && !latched;

   always_comb begin
      next_ss_done = ss_done;
      next_ldo_off = ldo_off;
      next_latched = latched;
      next_retries = retries;
      next_scnt    = scnt;
      if (!latched) begin
         if (!ss_done) begin
            next_scnt = scnt + 1'b1;
            if (scnt == CNT_W'(SS_CYC - 1)) begin
               next_scnt    = '0;
               next_ss_done = 1'b1;
               next_ldo_off = 1'b0;
            end
         end
         if (uv_armed && uv) begin
            if (retries == 2'(MAX_RETRIES)) begin
               next_latched = 1'b1;
            end else begin
               next_retries = retries + 1'b1;
            end
            next_ldo_off = 1'b1;
            next_ss_done = 1'b0;
            next_scnt    = '0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ss_done <= 1'b0;
         ldo_off <= 1'b0;
         latched <= 1'b0;
         retries <= RETRY_RESET;
         scnt    <= '0;
      end else begin
         ss_done <= next_ss_done;
         ldo_off <= next_ldo_off;
         latched <= next_latched;
         retries <= next_retries;
         scnt    <= next_scnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output registers
   swrhs_ctl_t ctl;
   swrhs_ctl_t next_ctl;

   always_comb begin
      next_ctl.main_gate_oe       = !handed;
      next_ctl.standby_gate_drive = handed;
      next_ctl.ldo_standby        = handed;
      next_ctl.ldo_enable         = !ldo_off && !latched && !handed;
      next_ctl.ldo_latched_off    = latched;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctl <= '{main_gate_oe: 1'b1, standby_gate_drive: 1'b0,
                  ldo_enable: 1'b0, ldo_standby: 1'b0,
                  ldo_latched_off: 1'b0};
      end else begin
         ctl <= next_ctl;
      end
   end

   assign main_switch_gate_release_o_out    = 1'b0;
   assign main_switch_gate_release_oe_out   = ctl.main_gate_oe;
   assign standby_switch_gate_drive_out     = ctl.standby_gate_drive;
   assign standby_linear_regulator_en_out   = ctl.ldo_enable;
   assign standby_linear_regulator_stby_out = ctl.ldo_standby;
   assign standby_latched_off_out           = ctl.ldo_latched_off;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence handover_edge;
      $rose(handed);
   endsequence

   a_no_s45_to_s3: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $past(state) == SWRHS_S45 |-> state != SWRHS_S3)
      else $error("S4/S5 moved straight to S3");
   a_good_arms_count: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      state == SWRHS_ACTIVE && !good_seen && good12 |=> good_seen)
      else $error("12V good not registered");
   a_handover_wait: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(handed) |-> hcnt == (CNT_W+2)'(HO_CYC))
      else $error("Hand-over not after three soft-start periods");
   a_gate_release: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      handover_edge |=> !main_switch_gate_release_oe_out)
      else $error("Main gate not released at hand-over");
   a_standby_gate: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      handover_edge |=> standby_switch_gate_drive_out
      && standby_linear_regulator_stby_out)
      else $error("Standby gate or regulator standby missing");
   a_uv_disable: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      uv_armed && uv |=> ##1 !standby_linear_regulator_en_out)
      else $error("Regulator not disabled on UV");
   a_uv_only_sleep: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      state == SWRHS_ACTIVE |=> $stable(retries) && $stable(latched))
      else $error("UV acted on while active");
   a_latch_hold: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      latched |=> latched && !standby_linear_regulator_en_out)
      else $error("Latch-off released");
   a_fourth_uv: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      uv_armed && uv && retries == 2'(MAX_RETRIES) |=> latched)
      else $error("Fourth UV did not latch off");
endmodule

// File: rtl/swrhs_pkg.sv
// Constants and carrier types of the sleep/wake rail hand-over sequencer.
// Assumes a 100 MHz clk_in and digitised comparator outputs from the analog.
package swrhs_pkg;
   localparam int    CLK_MHZ         = 100;
   localparam real   SOFT_START_MS   = 8.2;
   localparam int    SS_CYCLES       = int'(SOFT_START_MS * 1000.0 * CLK_MHZ);
   localparam int    HANDOVER_PERIODS = 3;
   localparam int    MAX_RETRIES     = 3;
   localparam int    UV_NOMINAL_MV   = 3300;
   localparam int    UV_TRIP_MV      = 2475;
   localparam real   S0_S3_DELAY_US  = 58.0;
   localparam int    S3_DELAY_CYCLES = int'(S0_S3_DELAY_US * CLK_MHZ);
   localparam logic [1:0] RETRY_RESET = 2'h0;
   localparam int    CNT_W           = 24;

   typedef enum logic [2:0] {
      SWRHS_ACTIVE = 3'b001,
      SWRHS_S3     = 3'b010,
      SWRHS_S45    = 3'b100
   } swrhs_sleep_t;

   typedef struct packed {
      logic main_gate_oe;
      logic standby_gate_drive;
      logic ldo_enable;
      logic ldo_standby;
      logic ldo_latched_off;
   } swrhs_ctl_t;
endpackage

// File: rtl/swrhs_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pin is a slow level relative to clk_in.
module swrhs_sync
   import swrhs_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   always_comb begin
      next_stage = {stage[1:0], pin_in};
      next_level = (stage[2] == stage[1]) ? stage[1] : level_out;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stage     <= 3'h0;
         level_out <= 1'b0;
      end else begin
         stage     <= next_stage;
         level_out <= next_level;
      end
   end
endmodule

// File: bench/swrhs_host_model.sv
// Host sleep pins, main 12V supply and aux 3.3V comparator.
// Assumes the bench picks the state: 0 = S0, 1 = S3, 2 = S4/S5.
module swrhs_host_model (
   input  wire logic       clk_in,
   input  wire logic [1:0] state_req_in,
   input  wire logic       fault_in,
   output logic            sleep_s3_n_out,
   output logic            sleep_s5_n_out,
   output logic            rail_12v_good_out,
   output logic            aux_3v3_uv_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ramp = 4'h0;
   ////////////////////////////////////////////////////////////////////////
   assign sleep_s3_n_out = (state_req_in == 2'h0);
   assign sleep_s5_n_out = (state_req_in != 2'h2);
   assign aux_3v3_uv_out = fault_in;
   // 12V ramps only while in S0
   assign rail_12v_good_out = (ramp == 4'ha);
   always @(posedge clk_in) begin
      if (state_req_in != 2'h0) ramp <= 4'h0;
      else if (ramp != 4'ha) ramp <= ramp + 4'h1;
   end
endmodule

// File: bench/sleep_wake_rail_handover_sequencer_bench.sv
// Self-checking bench of the rail hand-over sequencer.
// Assumes soft-start is shortened to SS cycles.
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin \
   mismatches++; $display("BAD %s exp %0h got %0h", w, e, g); end end
module sleep_wake_rail_handover_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import swrhs_pkg::*;
   localparam int SS = 20;
   logic       clk_in = 1'b0;
   logic       resetn_in = 1'b0;
   logic [1:0] state_req = 2'h2;
   logic       fault = 1'b0;
   logic       s3_n, s5_n, good, uv, oe_o, oe, drive, en, stby, latch;
   int         mismatches = 0;
   int         check_count = 0;
   int         n;
   always #5 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////
   swrhs_host_model i_host (.clk_in(clk_in), .state_req_in(state_req),
      .fault_in(fault), .sleep_s3_n_out(s3_n), .sleep_s5_n_out(s5_n),
      .rail_12v_good_out(good), .aux_3v3_uv_out(uv));
   swrhs_top #(.SS_CYC(SS)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .sleep_s3_n_in(s3_n), .sleep_s5_n_in(s5_n),
      .rail_12v_good_in(good), .aux_3v3_uv_in(uv),
      .main_switch_gate_release_o_out(oe_o),
      .main_switch_gate_release_oe_out(oe),
      .standby_switch_gate_drive_out(drive),
      .standby_linear_regulator_en_out(en),
      .standby_linear_regulator_stby_out(stby),
      .standby_latched_off_out(latch));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   // Counts cycles until a watched output takes a level
   task automatic wait_sig(input int sel, input logic v, input int lim);
      n = 0;
      while ((sel == 0 ? oe : sel == 1 ? en : latch) !== v && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         $display("BAD wait %0d exp %0h got timeout", sel, v);
         final_report();
      end
   endtask
   task automatic t_reset_vals;
      tick(1);
      `CHK("oe", 1'b1, oe)
      `CHK("drive", 1'b0, drive)
      `CHK("en", 1'b0, en)
      `CHK("latch", 1'b0, latch)
      `CHK("pull", 1'b0, oe_o)
      `CHK("stby", 1'b0, stby)
   endtask
   // Regulator runs during its first ramp; UV then must be ignored
   task automatic t_soft_start;
      @(posedge clk_in) fault <= 1'b1;
      tick(SS / 2);
      `CHK("en ramp", 1'b1, en)
      @(posedge clk_in) fault <= 1'b0;
      tick(SS);
      `CHK("en early", 1'b1, en)
   endtask
   task automatic t_wake;
      @(posedge clk_in) state_req <= 2'h0;
      n = 0;
      while (good !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      `CHK("12v", 1'b1, good)
      if (good !== 1'b1) final_report();
      `CHK("pre 12v", 1'b1, oe)
      wait_sig(0, 1'b0, 3 * SS + 20);
      `CHK("delay", 1'b1, n >= 3 * SS)
      `CHK("drive", 1'b1, drive)
      `CHK("stby", 1'b1, stby)
      `CHK("pull", 1'b0, oe_o)
      @(posedge clk_in) fault <= 1'b1;
      tick(10);
      @(posedge clk_in) fault <= 1'b0;
      tick(SS);
      `CHK("uv in s0", 1'b0, latch)
      `CHK("still out", 1'b0, oe)
   endtask
   task automatic t_uv_retry;
      @(posedge clk_in) state_req <= 2'h2;
      wait_sig(1, 1'b1, 3 * SS);
      `CHK("rearm", 1'b1, n < SS)
      `CHK("gate back", 1'b1, oe)
      `CHK("stby back", 1'b0, stby)
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in) fault <= 1'b1;
         wait_sig(1, 1'b0, 12);
         @(posedge clk_in) fault <= 1'b0;
         if (i < 3) begin
            wait_sig(1, 1'b1, 2 * SS + 20);
            `CHK("retry gap", 1'b1, n >= SS - 3)
            `CHK("no latch", 1'b0, latch)
         end
      end
      wait_sig(2, 1'b1, 10);
      tick(3 * SS);
      `CHK("latched en", 1'b0, en)
      `CHK("latch", 1'b1, latch)
   endtask
   task automatic t_por_clear;
      @(posedge clk_in) resetn_in <= 1'b0;
      tick(3);
      `CHK("latch por", 1'b0, latch)
      @(posedge clk_in) resetn_in <= 1'b1;
      t_soft_start();
      `CHK("latch after", 1'b0, latch)
   endtask
   // Wake, then S3 entry after its delay; then S3 asked from S4/S5
   task automatic t_s3_entry;
      @(posedge clk_in) state_req <= 2'h0;
      wait_sig(0, 1'b0, 3 * SS + 40);
      @(posedge clk_in) state_req <= 2'h1;
      tick(S3_DELAY_CYCLES - 10);
      `CHK("s3 early", 1'b0, oe)
      wait_sig(0, 1'b1, 40);
      `CHK("s3 drive", 1'b0, drive)
      @(posedge clk_in) state_req <= 2'h2;
      tick(10);
      @(posedge clk_in) state_req <= 2'h1;
      tick(20);
      @(posedge clk_in) state_req <= 2'h2;
      tick(2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(100000 * 10);
      mismatches++;
      $display("BAD run exp done got timeout");
      final_report();
   end
   initial begin
      repeat (11) @(posedge clk_in);
      t_reset_vals();
      @(posedge clk_in) resetn_in <= 1'b1;
      t_soft_start();
      t_wake();
      t_uv_retry();
      t_por_clear();
      t_s3_entry();
      final_report();
   end
endmodule
